// ---- core/ccd_pkg.sv ----
// constants, opcodes and state codes of the core datapath
// Overview of operation
// - fetch and decode 24-bit words, variable opcodes
// - 23-bit program counter, 4M x 24 space
// - prefetch, one cycle except flow, double-move
// - zero-overhead repeat loops, interruptible at any point
// - sixteen 16-bit registers, data or address
// - last working register is the stack pointer
// - read, register read, write, fetch per cycle
// - data space linear 32K words, 64 Kbytes
// - upper data half maps to program page
// - 2 Kbytes DMA RAM inside data space
// - one-cycle 17x17 signed, unsigned, mixed multiply
// - 16/16 and 32/16 integer division
// - divide iterates in repeat, 19 cycles total
// - interrupted divide resumes without losing results
// - one-cycle shift left or right, 0-16 bits
// - EA bit 15 set: page joins low 15
package ccd_pkg;
  localparam int unsigned INSTR_W    = 24;
  localparam int unsigned PC_W       = 23;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned NREGS      = 16;
  localparam int unsigned RPT_W      = 14;
  localparam int unsigned PAGE_W     = 8;
  localparam int unsigned PC_HI_W    = 7;
  // instruction field positions
  localparam int unsigned OPC_LO     = 16;
  localparam int unsigned SHORT_LO   = 20;
  localparam int unsigned WD_LO      = 0;
  localparam int unsigned WS_LO      = 4;
  localparam int unsigned WB_LO      = 8;
  localparam int unsigned MODE_LO    = 12;
  localparam int unsigned LIT_LO     = 4;
  localparam int unsigned PSV_EN_BIT = 8;
  // reset values and steps
  localparam logic [22:0] PC_RESET     = 23'h000000;
  localparam logic [22:0] PC_STEP      = 23'h000002;
  localparam logic [15:0] WREG_RESET   = 16'h0000;
  localparam logic [15:0] SP_RESET     = 16'h0800;
  localparam logic [15:0] WORD_BYTES   = 16'h0002;
  localparam logic [3:0]  SP_IDX       = 4'hf;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;
  // dma ram window
  localparam logic [15:0] DMA_RAM_BASE = 16'h7800;
  localparam logic [15:0] DMA_RAM_END  = 16'h8000;
  // shifter and divider figures
  localparam logic [4:0]  SHIFT_MAX    = 5'h10;
  localparam logic [4:0]  DIV_STEPS    = 5'h10;
  localparam logic [4:0]  DIV_LAST     = 5'h11;
  localparam logic [13:0] DIV_RPT_CNT  = 14'h0011;
  localparam int unsigned DIV_CYCLES   = 19;
  // short and long opcodes
  localparam logic [3:0] OPC_MOVL  = 4'hf;
  localparam logic [7:0] OP_ADD    = 8'h01;
  localparam logic [7:0] OP_SUB    = 8'h02;
  localparam logic [7:0] OP_ADDM   = 8'h03;
  localparam logic [7:0] OP_LD     = 8'h04;
  localparam logic [7:0] OP_ST     = 8'h05;
  localparam logic [7:0] OP_MUL    = 8'h06;
  localparam logic [7:0] OP_SHL    = 8'h07;
  localparam logic [7:0] OP_LSR    = 8'h08;
  localparam logic [7:0] OP_ASR    = 8'h09;
  localparam logic [7:0] OP_REPEAT = 8'h0a;
  localparam logic [7:0] OP_DIV    = 8'h0b;
  localparam logic [7:0] OP_CALL   = 8'h0c;
  localparam logic [7:0] OP_RETURN = 8'h0d;
  localparam logic [7:0] OP_GOTO   = 8'h0e;
  localparam logic [7:0] OP_SETPSV = 8'h0f;
  localparam logic [7:0] OP_MOVD   = 8'h10;
  localparam logic [7:0] OP_RETFIE = 8'h11;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_PUSH2 = 4'b0010,
    ST_POP2  = 4'b0100,
    ST_MOVD2 = 4'b1000
  } ccd_state_t;
endpackage : ccd_pkg

// ---- core/ccd_divider.sv ----
// iterative restoring divider, one step per execution
`timescale 1ns/1ps
module ccd_divider
  import ccd_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        exec_i,
  input  wire logic        signed_i,
  input  wire logic [31:0] dividend_i,
  input  wire logic [15:0] divisor_i,
  output logic             done_o,
  output logic [15:0]      quot_o,
  output logic [15:0]      rem_o
);
  logic [4:0]  cnt_q, cnt_d;
  logic [16:0] r_q, r_d;
  logic [15:0] q_q, q_d;
  logic [15:0] dvs_q, dvs_d;
  logic        qneg_q, qneg_d;
  logic        rneg_q, rneg_d;
  logic [31:0] mag;
  logic [16:0] trial;

  ////////////////////////////////////////////////////////////////////////////
  // state moves only on a divide execution; interrupts leave it
  always_comb
  begin
    cnt_d  = cnt_q;
    r_d    = r_q;
    q_d    = q_q;
    dvs_d  = dvs_q;
    qneg_d = qneg_q;
    rneg_d = rneg_q;
    mag    = (signed_i && dividend_i[31]) ? 32'(-dividend_i) : dividend_i;
    trial  = {r_q[15:0], q_q[15]};
    if (exec_i)
    begin
      if (cnt_q == 5'h00)
      begin
        // load magnitudes and result signs
        r_d    = {1'b0, mag[31:16]};
        q_d    = mag[15:0];
        dvs_d  = (signed_i && divisor_i[15]) ? 16'(-divisor_i) : divisor_i;
        qneg_d = signed_i && (dividend_i[31] ^ divisor_i[15]);
        rneg_d = signed_i && dividend_i[31];
        cnt_d  = cnt_q + 5'h01;
      end
      else if (cnt_q <= DIV_STEPS)
      begin
        // one quotient bit per cycle
        if (trial >= {1'b0, dvs_q})
        begin
          r_d = trial - {1'b0, dvs_q};
          q_d = {q_q[14:0], 1'b1};
        end
        else
        begin
          r_d = trial;
          q_d = {q_q[14:0], 1'b0};
        end
        cnt_d = cnt_q + 5'h01;
      end
      else
      begin
        cnt_d = 5'h00; // result taken this execution
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // partial results survive pauses
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= 5'h00;
      r_q    <= 17'h00000;
      q_q    <= 16'h0000;
      dvs_q  <= 16'h0000;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      r_q    <= r_d;
      q_q    <= q_d;
      dvs_q  <= dvs_d;
      qneg_q <= qneg_d;
      rneg_q <= rneg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // signed results fixed up on the final execution
  assign done_o = exec_i && (cnt_q == DIV_LAST);
  assign quot_o = qneg_q ? 16'(-q_q) : q_q;
  assign rem_o  = rneg_q ? 16'(-r_q[15:0]) : r_q[15:0];
endmodule : ccd_divider

// ---- core/ccd_core.sv ----
// 16-bit core datapath: fetch, registers, alu, stack
`timescale 1ns/1ps
module ccd_core
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  output logic [ccd_pkg::PC_W-1:0]          pmem_addr_o,
  input  wire logic [ccd_pkg::INSTR_W-1:0]  pmem_data_i,
  output logic [ccd_pkg::PC_W-1:0]          psv_addr_o,
  output logic                              psv_rd_o,
  input  wire logic [ccd_pkg::INSTR_W-1:0]  psv_data_i,
  output logic [ccd_pkg::DATA_W-1:0]        dmem_raddr_o,
  output logic                              dmem_rd_o,
  input  wire logic [ccd_pkg::DATA_W-1:0]   dmem_rdata_i,
  output logic                              dmem_we_o,
  output logic [ccd_pkg::DATA_W-1:0]        dmem_waddr_o,
  output logic [ccd_pkg::DATA_W-1:0]        dmem_wdata_o,
  output logic                              dma_region_o,
  input  wire logic                         irq_req_i,
  input  wire logic [ccd_pkg::PC_W-1:0]     irq_vec_i,
  output logic                              irq_ack_o,
  output logic                              rpt_active_o
);
  import ccd_pkg::*;

  logic [PC_W-1:0]     pc_q, pc_d, ir_pc_q, ir_pc_d;
  logic [INSTR_W-1:0]  ir_q, ir_d;
  logic                ir_vld_q, ir_vld_d;
  logic [DATA_W-1:0]   w_q [NREGS];
  logic [DATA_W-1:0]   w_d [NREGS];
  logic [RPT_W-1:0]    rcnt_q, rcnt_d, rsh_q, rsh_d;
  logic [PAGE_W-1:0]   page_q, page_d;
  logic                psv_en_q, psv_en_d;
  ccd_state_t          state_q, state_d;
  logic [DATA_W-1:0]   tmp_q, tmp_d;
  logic                retfie_q, retfie_d;
  logic                we_q, we_d, ack_q, ack_d;
  logic [DATA_W-1:0]   waddr_q, waddr_d, wdata_q, wdata_d;

  logic [7:0]          opc;
  logic [3:0]          wd, ws, wb, wd1, ws1;
  logic [1:0]          mode;
  logic                is_movl, run_ok, exec, is_pop, reading, stack_rd, psv_hit;
  logic [DATA_W-1:0]   rs, rb, sp, ea_rd, ea_wr, mem_rd, rd_data, shl_res, shr_res;
  logic [PC_W-1:0]     ret_addr;
  logic [4:0]          amt;
  logic [31:0]         sh_ext, shl_ext, dividend;
  logic [16:0]         a17, b17;
  logic signed [33:0]  prod;
  logic                div_exec, div_done, advance;
  logic [15:0]         div_quot, div_rem;

  ////////////////////////////////////////////////////////////////////////////
  // decode: a 4-bit short opcode or an 8-bit long one
  assign is_movl = (ir_q[SHORT_LO +: 4] == OPC_MOVL);
  assign opc     = ir_q[OPC_LO +: 8];
  assign wd      = ir_q[WD_LO +: 4];
  assign ws      = ir_q[WS_LO +: 4];
  assign wb      = ir_q[WB_LO +: 4];
  assign mode    = ir_q[MODE_LO +: 2];
  assign wd1     = wd + 4'h1;
  assign ws1     = ws + 4'h1;
  assign rs      = w_q[ws]; // any register as data or address
  assign rb      = w_q[wb];
  assign sp      = w_q[SP_IDX];
  assign run_ok  = (state_q == ST_RUN) && ir_vld_q;
  assign exec    = run_ok && !irq_req_i; // interrupt wins over execution
  assign is_pop  = exec && !is_movl && ((opc == OP_RETURN) || (opc == OP_RETFIE));

  ////////////////////////////////////////////////////////////////////////////
  // linear 64 Kbyte address generation
  always_comb
  begin
    stack_rd = is_pop || (state_q == ST_POP2);
    if (stack_rd)
      ea_rd = sp - WORD_BYTES;
    else if (state_q == ST_MOVD2)
      ea_rd = rs + WORD_BYTES;
    else
      ea_rd = rs;
    reading = stack_rd || (state_q == ST_MOVD2) ||
              (exec && !is_movl && ((opc == OP_LD) || (opc == OP_ADDM) || (opc == OP_MOVD)));
    psv_hit = psv_en_q && ea_rd[15] && !stack_rd;
  end

  // upper half read from program page
  assign psv_addr_o   = {page_q, ea_rd[14:0]};
  assign psv_rd_o     = reading && psv_hit;
  assign dmem_rd_o    = reading && !psv_hit;
  assign dmem_raddr_o = {ea_rd[15:1], 1'b0};
  assign dma_region_o = (ea_rd >= DMA_RAM_BASE) && (ea_rd < DMA_RAM_END);
  // registered write: forward it to a same-address read
  assign mem_rd  = (we_q && (waddr_q == dmem_raddr_o)) ? wdata_q : dmem_rdata_i;
  assign rd_data = psv_hit ? psv_data_i[15:0] : mem_rd; // low program word only
  assign ea_wr   = w_q[wd];

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle 17x17 multiply, per-operand sign
  assign a17  = {mode[0] & rs[15], rs};
  assign b17  = {mode[1] & rb[15], rb};
  assign prod = $signed(a17) * $signed(b17);

  // barrel shifter, amount clamped at 16
  always_comb
  begin
    amt     = ((rb[15:5] != 11'h000) || (rb[4:0] > SHIFT_MAX)) ? SHIFT_MAX : rb[4:0];
    sh_ext  = {{16{(opc == OP_ASR) & rs[15]}}, rs};
    shl_ext = {16'h0000, rs} << amt;
    shr_res = 16'(sh_ext >> amt);
    shl_res = shl_ext[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider stepped once per repeated execution
  assign div_exec = exec && !is_movl && (opc == OP_DIV);
  assign dividend = mode[1] ? {w_q[ws1], rs} :
                    (mode[0] ? {{16{rs[15]}}, rs} : {16'h0000, rs});

  ccd_divider u_div (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .exec_i     (div_exec),
    .signed_i   (mode[0]),
    .dividend_i (dividend),
    .divisor_i  (rb),
    .done_o     (div_done),
    .quot_o     (div_quot),
    .rem_o      (div_rem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execute: one cycle except flow and double move
  always_comb
  begin
    pc_d     = pc_q;
    ir_d     = ir_q;
    ir_vld_d = ir_vld_q;
    ir_pc_d  = ir_pc_q;
    w_d      = w_q;
    rcnt_d   = rcnt_q;
    rsh_d    = rsh_q;
    page_d   = page_q;
    psv_en_d = psv_en_q;
    state_d  = state_q;
    tmp_d    = tmp_q;
    retfie_d = retfie_q;
    we_d     = 1'b0;
    waddr_d  = waddr_q;
    wdata_d  = wdata_q;
    ack_d    = 1'b0;
    advance  = 1'b0;
    ret_addr = ir_pc_q + PC_STEP;
    unique case (state_q)
      ST_RUN:
      begin
        if (!ir_vld_q)
          advance = 1'b1; // refill after a flush
        else if (irq_req_i)
        begin
          // break in anywhere, also mid-loop; save remaining count
          we_d           = 1'b1;
          waddr_d        = sp;
          wdata_d        = ir_pc_q[15:0];
          tmp_d          = 16'(ir_pc_q[PC_W-1:16]);
          w_d[SP_IDX]    = sp + WORD_BYTES;
          rsh_d          = rcnt_q;
          rcnt_d         = '0;
          pc_d           = irq_vec_i;
          ir_vld_d       = 1'b0;
          ack_d          = 1'b1;
          state_d        = ST_PUSH2;
        end
        else
        begin
          // hold the word while the loop count runs down
          advance = (rcnt_q == '0);
          if (rcnt_q != '0)
            rcnt_d = rcnt_q - 14'h0001;
          if (is_movl)
            w_d[wd] = ir_q[LIT_LO +: 16];
          else
          begin
            case (opc)
              OP_ADD: w_d[wd] = rs + rb;
              OP_SUB: w_d[wd] = rs - rb;
              OP_ADDM:
              begin
                // read, register read, write at once
                we_d    = !(psv_en_q && ea_wr[15]); // mapped half is read-only
                waddr_d = {ea_wr[15:1], 1'b0};
                wdata_d = rd_data + rb;
              end
              OP_LD: w_d[wd] = rd_data;
              OP_ST:
              begin
                we_d    = !(psv_en_q && ea_wr[15]);
                waddr_d = {ea_wr[15:1], 1'b0};
                wdata_d = rs;
              end
              OP_MUL:
              begin
                w_d[wd]  = prod[15:0];
                w_d[wd1] = prod[31:16];
              end
              OP_SHL: w_d[wd] = shl_res;
              OP_LSR, OP_ASR: w_d[wd] = shr_res;
              OP_REPEAT: rcnt_d = ir_q[RPT_W-1:0];
              OP_DIV:
              begin
                if (div_done)
                begin
                  w_d[wd]  = div_quot;
                  w_d[wd1] = div_rem;
                end
              end
              OP_CALL:
              begin
                we_d        = 1'b1;
                waddr_d     = sp;
                wdata_d     = ret_addr[15:0];
                tmp_d       = 16'(ret_addr[PC_W-1:16]);
                w_d[SP_IDX] = sp + WORD_BYTES;
                pc_d        = PC_W'(rs);
                ir_vld_d    = 1'b0;
                advance     = 1'b0;
                state_d     = ST_PUSH2;
              end
              OP_GOTO:
              begin
                pc_d     = PC_W'(rs);
                ir_vld_d = 1'b0;
                advance  = 1'b0;
              end
              OP_RETURN, OP_RETFIE:
              begin
                tmp_d       = rd_data; // upper return bits
                w_d[SP_IDX] = sp - WORD_BYTES;
                retfie_d    = (opc == OP_RETFIE);
                ir_vld_d    = 1'b0;
                advance     = 1'b0;
                state_d     = ST_POP2;
              end
              OP_SETPSV:
              begin
                page_d   = ir_q[PAGE_W-1:0];
                psv_en_d = ir_q[PSV_EN_BIT];
              end
              OP_MOVD:
              begin
                w_d[wd] = rd_data; // second word next cycle
                advance = 1'b0;
                state_d = ST_MOVD2;
              end
              default: ; // unknown: no-op
            endcase
          end
        end
      end
      ST_PUSH2:
      begin
        we_d        = 1'b1;
        waddr_d     = sp;
        wdata_d     = tmp_q;
        w_d[SP_IDX] = sp + WORD_BYTES;
        state_d     = ST_RUN;
      end
      ST_POP2:
      begin
        pc_d        = {tmp_q[PC_HI_W-1:0], rd_data};
        w_d[SP_IDX] = sp - WORD_BYTES;
        if (retfie_q)
          rcnt_d = rsh_q; // loop resumes with its saved count
        state_d     = ST_RUN;
      end
      ST_MOVD2:
      begin
        w_d[wd1] = rd_data;
        advance  = 1'b1;
        state_d  = ST_RUN;
      end
    endcase
    // prefetch next word during execution
    if (advance)
    begin
      ir_d     = pmem_data_i;
      ir_pc_d  = pc_q;
      ir_vld_d = 1'b1;
      pc_d     = pc_q + PC_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pc_q        <= PC_RESET;
      ir_q        <= '0;
      ir_vld_q    <= 1'b0;
      ir_pc_q     <= PC_RESET;
      w_q         <= '{default: WREG_RESET};
      w_q[SP_IDX] <= SP_RESET;
      rcnt_q      <= '0;
      rsh_q       <= '0;
      page_q      <= PAGE_RESET;
      psv_en_q    <= 1'b0;
      state_q     <= ST_RUN;
      tmp_q       <= '0;
      retfie_q    <= 1'b0;
      we_q        <= 1'b0;
      waddr_q     <= '0;
      wdata_q     <= '0;
      ack_q       <= 1'b0;
    end
    else
    begin
      pc_q     <= pc_d;
      ir_q     <= ir_d;
      ir_vld_q <= ir_vld_d;
      ir_pc_q  <= ir_pc_d;
      w_q      <= w_d;
      rcnt_q   <= rcnt_d;
      rsh_q    <= rsh_d;
      page_q   <= page_d;
      psv_en_q <= psv_en_d;
      state_q  <= state_d;
      tmp_q    <= tmp_d;
      retfie_q <= retfie_d;
      we_q     <= we_d;
      waddr_q  <= waddr_d;
      wdata_q  <= wdata_d;
      ack_q    <= ack_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  assign pmem_addr_o  = pc_q;
  assign dmem_we_o    = we_q;
  assign dmem_waddr_o = waddr_q;
  assign dmem_wdata_o = wdata_q;
  assign irq_ack_o    = ack_q;
  assign rpt_active_o = (rcnt_q != '0);
endmodule : ccd_core

// ---- testbench/ccd_core_sva.sv ----
// port-level assertions for the core datapath
`timescale 1ns/1ps
module ccd_core_sva
  import ccd_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [22:0] pmem_addr_o,
  input wire logic        psv_rd_o,
  input wire logic [15:0] dmem_raddr_o,
  input wire logic        dmem_rd_o,
  input wire logic        dmem_we_o,
  input wire logic [15:0] dmem_waddr_o,
  input wire logic [15:0] dmem_wdata_o,
  input wire logic        dma_region_o,
  input wire logic        irq_req_i,
  input wire logic [22:0] irq_vec_i,
  input wire logic        irq_ack_o,
  input wire logic        rpt_active_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  // fetch from zero after reset
  chk_reset_fetch: assert property ($fell(rst_i) |-> pmem_addr_o == PC_RESET)
    else $error("fetch not at zero after reset");
  chk_pc_even: assert property (pmem_addr_o[0] == 1'b0)
    else $error("odd fetch address");
  // interrupt needs a request, jumps to vector
  chk_ack_cause: assert property (irq_ack_o |-> $past(irq_req_i))
    else $error("ack without request");
  chk_vec_jump: assert property (irq_ack_o |-> pmem_addr_o == $past(irq_vec_i))
    else $error("fetch not at vector");
  chk_ack_single: assert property (irq_ack_o |=> !irq_ack_o)
    else $error("ack longer than one cycle");
  // two stack words upwards, high word 7 bits
  chk_push_pair: assert property (irq_ack_o |-> dmem_we_o ##1 (dmem_we_o &&
    dmem_waddr_o == $past(dmem_waddr_o) + WORD_BYTES && dmem_wdata_o[15:7] == 9'h000))
    else $error("stack push pair wrong");
  chk_dma_flag: assert property (dma_region_o ==
    (dmem_raddr_o >= DMA_RAM_BASE && dmem_raddr_o < DMA_RAM_END))
    else $error("dma region flag wrong");
  chk_rd_align: assert property (dmem_rd_o |-> dmem_raddr_o[0] == 1'b0)
    else $error("odd data read address");
  cover property (irq_ack_o);
  cover property ($rose(rpt_active_o));
  cover property (psv_rd_o);
  cover property (dma_region_o && dmem_rd_o);
endmodule : ccd_core_sva

bind ccd_core ccd_core_sva u_sva (.*);

// ---- testbench/ccd_mem_model.sv ----
// program and data memory, same-cycle reads
`timescale 1ns/1ps
module ccd_mem_model
(
  input  wire logic        ref_clk_i,
  input  wire logic [22:0] pc_addr_i,
  output logic [23:0]      pmem_data_o,
  input  wire logic [22:0] psv_addr_i,
  input  wire logic        psv_rd_i,
  output logic [23:0]      psv_data_o,
  input  wire logic [15:0] rd_addr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rd_data_o,
  input  wire logic        we_i,
  input  wire logic [15:0] wr_addr_i,
  input  wire logic [15:0] wr_data_i
);
  logic [23:0] pm [0:2047];  // keeps page bit 0
  logic [15:0] dm [0:32767];
  logic [23:0] pw;
  initial foreach (dm[i]) dm[i] = 16'(i) ^ 16'ha5a5;
  // unselected: inverse, so stale data fails
  assign pmem_data_o = pm[{pc_addr_i[15], pc_addr_i[10:1]}];
  assign pw          = pm[{psv_addr_i[15], psv_addr_i[10:1]}];
  assign psv_data_o  = psv_rd_i ? pw : ~pw;
  assign rd_data_o   = rd_i ? dm[rd_addr_i[15:1]] : ~dm[rd_addr_i[15:1]];
  always @(posedge ref_clk_i)
    if (we_i) dm[wr_addr_i[15:1]] <= wr_data_i;
endmodule : ccd_mem_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the core datapath
`timescale 1ns/1ps
module tb_top;
  import ccd_pkg::*;
  logic        ref_clk_i, rst_i, irq_req_i, psv_rd, rd_en, wr_en, dma_hit, irq_ack, rpt_act;
  logic [22:0] irq_vec_i, pm_addr, psv_addr, watch, irq_at;
  logic [23:0] pm_data, psv_data;
  logic [15:0] rd_addr, rd_data, wr_addr, wr_data, st_addr, seed;
  logic [31:0] exp_q[$], got_q[$];
  int          bad_count, compares, pc_n, stall_n;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  ccd_core DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pmem_addr_o(pm_addr),
    .pmem_data_i(pm_data), .psv_addr_o(psv_addr), .psv_rd_o(psv_rd), .psv_data_i(psv_data),
    .dmem_raddr_o(rd_addr), .dmem_rd_o(rd_en), .dmem_rdata_i(rd_data), .dmem_we_o(wr_en),
    .dmem_waddr_o(wr_addr), .dmem_wdata_o(wr_data), .dma_region_o(dma_hit),
    .irq_req_i(irq_req_i), .irq_vec_i(irq_vec_i), .irq_ack_o(irq_ack), .rpt_active_o(rpt_act));
  ccd_mem_model u_mem (.ref_clk_i(ref_clk_i), .pc_addr_i(pm_addr), .pmem_data_o(pm_data),
    .psv_addr_i(psv_addr), .psv_rd_i(psv_rd), .psv_data_o(psv_data), .rd_addr_i(rd_addr),
    .rd_i(rd_en), .rd_data_o(rd_data), .we_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data));

  // log writes, count held fetch
  always @(posedge ref_clk_i)
  begin
    if (!rst_i && wr_en === 1'b1) got_q.push_back({wr_addr, wr_data});
    if (pm_addr === watch) stall_n++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd
  function automatic logic [23:0] op(logic [7:0] o, logic [1:0] m, logic [3:0] b, s, d);
    return {o, 2'b00, m, b, s, d};
  endfunction : op
  function automatic logic [31:0] mulref(logic [15:0] a, b, logic [1:0] m);
    logic signed [16:0] x, y;
    logic signed [33:0] p;
    x = {m[0] & a[15], a};
    y = {m[1] & b[15], b};
    p = x * y;
    return p[31:0];
  endfunction : mulref
  function automatic logic [15:0] shref(int o, logic [15:0] a, c);
    logic [4:0]         n;
    logic signed [15:0] s;
    n = (c > 16) ? 5'h10 : c[4:0];
    s = a;
    s = s >>> n;
    case (o)
      0: return a << n;
      1: return a >> n;
      default: return s;
    endcase
  endfunction : shref
  // {rem, quot}
  function automatic logic [31:0] divref(logic [15:0] n, h, d, logic [1:0] m);
    logic signed [15:0] sn, sd;
    logic [31:0]        w;
    sn = n;
    sd = d;
    w = {h, n};
    if (m[0]) return {16'(sn % sd), 16'(sn / sd)};
    return {16'(w % 32'(d)), 16'(w / 32'(d))};
  endfunction : divref
  ////////////////////////////////////////////////////////////////////////////////
  task automatic emit(input logic [23:0] w);
    u_mem.pm[pc_n] = w;
    pc_n++;
  endtask : emit
  task automatic movl(input logic [3:0] d, input logic [15:0] v);
    emit({OPC_MOVL, v, d});
  endtask : movl
  // each store is expected
  task automatic store(input logic [3:0] r, input logic [15:0] v);
    movl(4'h0, st_addr);
    emit(op(OP_ST, 2'b00, 4'h0, r, 4'h0));
    exp_q.push_back({st_addr, v});
    st_addr += 16'h0002;
  endtask : store
  task automatic start();
    rst_i = 1'b1;
    foreach (u_mem.pm[i]) u_mem.pm[i] = '0;
    pc_n = 0;
    st_addr = 16'h1000;
    stall_n = 0;
    watch = '1;
    irq_at = '1;
    exp_q.delete();
    got_q.delete();
  endtask : start
  task automatic run(input string name);
    repeat (6) tick();
    rst_i = 1'b0;
    for (int n = 0; n < 3000 && got_q.size() < exp_q.size(); n++) tick();
    repeat (20) tick();
    check(got_q.size() == exp_q.size(), "write count");
    foreach (exp_q[i]) check(got_q[i] === exp_q[i], $sformatf("write %0d", i));
    $display("test %s done", name);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_alu();
    logic [15:0] a, b, c;
    start();
    for (int k = 0; k < 2; k++)
    begin
      a = k ? 16'hffff : rnd();
      b = k ? 16'h8000 : rnd();
      movl(4'h1, a);
      movl(4'h2, b);
      emit(op(OP_ADD, 2'b00, 4'h2, 4'h1, 4'h3));
      store(4'h3, a + b);
      emit(op(OP_SUB, 2'b00, 4'h2, 4'h1, 4'h3));
      store(4'h3, a - b);
      for (int m = 0; m < 4; m++)
      begin
        emit(op(OP_MUL, 2'(m), 4'h2, 4'h1, 4'h6));
        store(4'h6, 16'(mulref(a, b, 2'(m))));
        store(4'h7, 16'(mulref(a, b, 2'(m)) >> 16));
      end
    end
    a = rnd();
    movl(4'h1, a);
    // amounts 0, random, 16, over
    for (int j = 0; j < 4; j++)
    begin
      c = (j == 1) ? (rnd() & 16'h000f) : 16'(j * 8);
      movl(4'h5, c);
      for (int o = 0; o < 3; o++)
      begin
        emit(op(OP_SHL + 8'(o), 2'b00, 4'h5, 4'h1, 4'h8));
        store(4'h8, shref(o, a, c));
      end
    end
    movl(4'h9, 16'h0000);
    emit({OP_REPEAT, 2'b00, 14'h0003});
    emit(op(OP_ADD, 2'b00, 4'h1, 4'h9, 4'h9));
    store(4'h9, a * 16'h0004);
    c = rnd();
    u_mem.dm[16'h1000] = c;
    u_mem.dm[16'h1001] = ~c;
    u_mem.dm[DMA_RAM_BASE[15:1]] = a;
    movl(4'hb, 16'h2000);
    emit(op(OP_MOVD, 2'b00, 4'h0, 4'hb, 4'hc));
    store(4'hc, c);
    store(4'hd, ~c);
    movl(4'hb, DMA_RAM_BASE);
    emit(op(OP_LD, 2'b00, 4'h0, 4'hb, 4'hc));
    store(4'hc, a);
    run("alu");
  endtask : test_alu
  // irq mid-divide, held until ack
  task automatic pulse_irq();
    for (int n = 0; n < 3000 && pm_addr !== irq_at; n++) tick();
    repeat (5) tick();
    irq_req_i = 1'b1;
    for (int n = 0; n < 20 && irq_ack !== 1'b1; n++) tick();
    irq_req_i = 1'b0;
  endtask : pulse_irq
  task automatic test_div();
    logic [15:0] n, d, h;
    logic [31:0] r;
    logic [22:0] at;
    start();
    u_mem.pm[11'h200] = op(OP_RETFIE, 2'b00, 4'h0, 4'h0, 4'h0);
    for (int m = 0; m < 3; m++)
    begin
      n = rnd();
      d = rnd() | (m == 2 ? 16'h8001 : 16'h0001);
      h = 16'(m >> 1);
      r = divref(n, h, d, 2'(m));
      movl(4'h1, n);
      movl(4'h2, h);
      movl(4'h3, d);
      emit({OP_REPEAT, 2'b00, DIV_RPT_CNT});
      at = 23'(pc_n * 2);
      emit(op(OP_DIV, 2'(m), 4'h3, 4'h1, 4'h6));
      if (m == 0) watch = at + PC_STEP;
      if (m == 1)
      begin
        irq_at = at + PC_STEP;
        exp_q.push_back({SP_RESET, at[15:0]});
        exp_q.push_back({SP_RESET + WORD_BYTES, 9'h000, at[22:16]});
      end
      store(4'h6, r[15:0]);
      store(4'h7, r[31:16]);
    end
    h = rnd();
    n = rnd() & 16'h07fe;
    u_mem.pm[{1'b1, n[10:1]}] = {8'h5a, h};
    emit({OP_SETPSV, 7'h00, 1'b1, 7'(rnd()), 1'b1});
    movl(4'hb, 16'h8000 | n);
    emit(op(OP_LD, 2'b00, 4'h0, 4'hb, 4'hc));
    store(4'hc, h);
    emit(op(OP_ST, 2'b00, 4'h0, 4'hc, 4'hb));  // mapped write must vanish
    store(4'hc, h);
    fork
      pulse_irq();
    join_none
    run("divide");
    check(stall_n == DIV_CYCLES - 1, "divide length");
  endtask : test_div
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // runs need under 10k cycles
  initial
  begin
    #100000;
    check(1'b0, "watchdog expired");
    finish_test();
  end
  initial
  begin
    rst_i = 1'b1;
    irq_req_i = 1'b0;
    irq_vec_i = 23'h000400;
    seed = 16'h0015;
    bad_count = 0;
    compares = 0;
    tick();
    test_alu();
    test_div();
    finish_test();
  end
endmodule : tb_top
